// ### rtl/smci_defines.svh
// Purpose: constants for the mux, configuration and interrupt registers
// Assumes: 4-bit register fields, 20 MHz core clock
// Notes:   offsets are the register addresses seen by the serial frame
`ifndef SMCI_DEFINES_SVH
`define SMCI_DEFINES_SVH

`define SMCI_ADDR_MUX        4'hC
`define SMCI_ADDR_CFG        4'hD
`define SMCI_ADDR_MASK       4'hE
`define SMCI_ADDR_SRC        4'hF
`define SMCI_MUX_DIV_BIT     3
`define SMCI_CFG_X8_BIT      2
`define SMCI_MASK_HS_BIT     3
`define SMCI_MASK_LS_BIT     2
`define SMCI_MASK_LIN_BIT    1
`define SMCI_MASK_VM_BIT     0
`define SMCI_MUX_RESET       4'h8
`define SMCI_CFG_RESET       4'h0
`define SMCI_MASK_RESET      4'hF
`define SMCI_SEL_OFF         3'h0
`define SMCI_SEL_TEMP        3'h2
`define SMCI_SEL_BATTERY_SENSE_INPUT      3'h3
`define SMCI_SEL_WAKE1       3'h4
`define SMCI_SEL_WAKE2       3'h5
`define SMCI_SRC_NONE        4'h0
`define SMCI_GAP_NS          10000
`define SMCI_CLK_MHZ         20
`define SMCI_GAP_CYCLES      ((`SMCI_GAP_NS * `SMCI_CLK_MHZ + 999) / 1000)

`endif

// ### rtl/smci_irq_prio.sv
// Purpose: picks the highest-priority pending source and gives its code
// Assumes: bit 0 of pending is code 1, the highest priority
// Notes:   purely combinational
`timescale 1ns/1ps
module smci_irq_prio (
    // pending sources
    input  wire logic [5:0] pending_i,
    // result
    output logic      [3:0] code_o,
    output logic      [5:0] onehot_o
);
    always_comb begin
        code_o   = 4'h0;
        onehot_o = 6'h00;
        for (int i = 5; i >= 0; i--) begin
            if (pending_i[i]) begin
                code_o   = 4'(i + 1);
                onehot_o = 6'(1 << i);
            end
        end
    end
endmodule

// ### rtl/smci_pkg.sv
// Purpose: shared types for the mux, configuration and interrupt registers
// Assumes: used together with smci_defines.svh
// Notes:   none
package smci_pkg;

    typedef enum logic [2:0] {
        SMCI_IRQ_IDLE = 3'b001,
        SMCI_IRQ_LOW  = 3'b010,
        SMCI_IRQ_GAP  = 3'b100
    } smci_irq_state_t;

    // register access from the serial frame decoder
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [3:0] addr;
        logic [3:0] data;
    } smci_access_t;

    // raw event pulses from the surrounding blocks
    typedef struct packed {
        logic wake_input;
        logic hs_overtemp;
        logic ls_overtemp;
        logic lin_wake;
        logic receive_line_short;
        logic transmit_dominant_timeout;
        logic lin_overtemp;
        logic supply_undervoltage;
        logic vdd_overtemp_prewarn;
        logic supply_overvoltage;
        logic forced_wake;
    } smci_events_t;

endpackage

// ### rtl/smci_regs.sv
// Purpose: mux, cyclic multiplier, interrupt mask and source registers
// Assumes: access strobes are one-cycle pulses from the frame decoder
// Notes:   read data is the value returned in the same serial frame
`timescale 1ns/1ps
`include "smci_defines.svh"

// Functional notes
// - grounded config pin: watchdog off, no timeouts
// - window-open flag follows watchdog window state
// - mux bit three selects wake divider
// - low three mux bits select analog source
// - buffer off when disabled, stop or sleep
// - config bit two multiplies cyclic interval eight
// - masked source gives neither irq nor code
// - prewarning and undervoltage never masked
// - mask write returns source code
// - mask bits high, low, bus, voltage; reset ones
// - voltage mask gates only overvoltage interrupt
// - source read acknowledges, releases irq if idle
// - others pending: irq high gap, then low
// - source code zero when nothing pending
// - report pending sources one by one, priority
// - source codes one through six as listed
// - bus short, dominant timeout, overtemp give code four
// - interrupt output is active low
module smci_regs
    import smci_pkg::*;
#(
    parameter int GAP_CYCLES = `SMCI_GAP_CYCLES
) (
    // clock and reset
    input  wire logic         clock_i,
    input  wire logic         reset_n_i,
    // reset causes and mode
    input  wire logic         power_on_i,
    input  wire logic         reset_mode_i,
    input  wire logic         ext_reset_i,
    input  wire logic         low_power_mode_i,
    // watchdog status
    input  wire logic         watchdog_config_pin_i,
    input  wire logic         window_open_i,
    // register access
    input  wire smci_access_t access_i,
    input  wire smci_events_t events_i,
    // register outputs
    output logic        [3:0] read_data_o,
    output logic              watchdog_disabled_flag_o,
    output logic              watchdog_window_open_flag_o,
    output logic              suppress_timeouts_o,
    output logic              skip_to_normal_o,
    output logic              wake_input_divider_select_o,
    output logic        [2:0] analog_source_select_o,
    output logic              analog_buffer_enable_o,
    output logic              cyclic_period_times_eight_o,
    output logic        [3:0] interrupt_group_mask_o,
    output logic        [3:0] irq_source_code_bits_o,
    output logic              irq_n_o
);

    typedef struct packed {
        logic [3:0]      rdata;
        logic            wd_off;
        logic            win_open;
        logic            divider;
        logic [2:0]      source_sel;
        logic            buf_en;
        logic            times8;
        logic [3:0]      mask;
        logic [5:0]      pending;
        logic [3:0]      code;
        logic            irq_n;
        smci_irq_state_t state;
        logic [15:0]     gap_cnt;
    } smci_state_t;

    smci_state_t st_q;
    smci_state_t st_d;

    logic [5:0]  raw_set;
    logic [5:0]  next_pending;
    logic [5:0]  ack_bit;
    logic [3:0]  top_code;
    logic [3:0]  next_code;
    logic        mask_wr;
    logic        src_rd;
    logic        clear_sel;

    smci_irq_prio u_prio (
        .pending_i (st_q.pending),
        .code_o    (top_code),
        .onehot_o  (ack_bit)
    );

    // the shown code must follow the pending set it is stored with
    smci_irq_prio u_prio_next (
        .pending_i (next_pending),
        .code_o    (next_code),
        .onehot_o  ()
    );

    always_comb begin
        mask_wr   = access_i.wr && access_i.addr == `SMCI_ADDR_MASK;
        src_rd    = access_i.rd && access_i.addr == `SMCI_ADDR_SRC;
        clear_sel = power_on_i || reset_mode_i || ext_reset_i;
        // masked sources never post; unmaskable ones always do
        raw_set[0] = events_i.wake_input;
        raw_set[1] = events_i.hs_overtemp
                   && st_q.mask[`SMCI_MASK_HS_BIT];
        raw_set[2] = events_i.ls_overtemp
                   && st_q.mask[`SMCI_MASK_LS_BIT];
        raw_set[3] = events_i.lin_wake
                   || ((events_i.receive_line_short
                        || events_i.transmit_dominant_timeout
                        || events_i.lin_overtemp)
                       && st_q.mask[`SMCI_MASK_LIN_BIT]);
        raw_set[4] = events_i.supply_undervoltage
                   || events_i.vdd_overtemp_prewarn
                   || (events_i.supply_overvoltage
                       && st_q.mask[`SMCI_MASK_VM_BIT]);
        raw_set[5] = events_i.forced_wake;
        // new events win over the acknowledge of the same source
        next_pending = st_q.pending;
        if (src_rd) begin
            next_pending = next_pending & ~ack_bit;
        end
        next_pending = next_pending | raw_set;
    end

    always_comb begin
        st_d          = st_q;
        st_d.wd_off   = ~watchdog_config_pin_i;
        st_d.win_open = window_open_i;
        st_d.pending  = next_pending;
        st_d.buf_en   = (st_q.source_sel != `SMCI_SEL_OFF)
                      && !low_power_mode_i;

        if (access_i.wr) begin
            case (access_i.addr)
                `SMCI_ADDR_MUX: begin
                    st_d.divider    = access_i.data[`SMCI_MUX_DIV_BIT];
                    st_d.source_sel = access_i.data[2:0];
                end
                `SMCI_ADDR_CFG: begin
                    st_d.times8 = access_i.data[`SMCI_CFG_X8_BIT];
                end
                `SMCI_ADDR_MASK: begin
                    st_d.mask = access_i.data;
                end
                default: begin
                end
            endcase
        end
        if (clear_sel) begin
            st_d.source_sel = `SMCI_SEL_OFF;
            st_d.buf_en     = 1'b0;
        end
        if (power_on_i) begin
            st_d.divider = 1'(`SMCI_MUX_RESET >> `SMCI_MUX_DIV_BIT);
            st_d.times8  = 1'b0;
            st_d.mask    = `SMCI_MASK_RESET;
        end

        // frame answer: source code on mask write or source read
        if (mask_wr || src_rd) begin
            st_d.rdata = top_code;
        end else begin
            st_d.rdata = 4'h0;
        end
        st_d.code = next_code;

        case (st_q.state)
            SMCI_IRQ_IDLE: begin
                st_d.irq_n = 1'b1;
                if (next_pending != 6'h00) begin
                    st_d.state = SMCI_IRQ_LOW;
                    st_d.irq_n = 1'b0;
                end
            end
            SMCI_IRQ_LOW: begin
                if (src_rd) begin
                    st_d.irq_n = 1'b1;
                    if (next_pending != 6'h00) begin
                        st_d.state   = SMCI_IRQ_GAP;
                        st_d.gap_cnt = 16'(GAP_CYCLES - 1);
                    end else begin
                        st_d.state = SMCI_IRQ_IDLE;
                    end
                end
            end
            SMCI_IRQ_GAP: begin
                st_d.irq_n = 1'b1;
                if (st_q.gap_cnt == 16'h0000) begin
                    if (next_pending != 6'h00) begin
                        st_d.state = SMCI_IRQ_LOW;
                        st_d.irq_n = 1'b0;
                    end else begin
                        st_d.state = SMCI_IRQ_IDLE;
                    end
                end else begin
                    st_d.gap_cnt = st_q.gap_cnt - 16'h0001;
                end
            end
            default: begin
                st_d.state = SMCI_IRQ_IDLE;
                st_d.irq_n = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            st_q.rdata      <= 4'h0;
            st_q.wd_off     <= 1'b0;
            st_q.win_open   <= 1'b0;
            st_q.divider    <= 1'b1;
            st_q.source_sel <= `SMCI_SEL_OFF;
            st_q.buf_en     <= 1'b0;
            st_q.times8     <= 1'b0;
            st_q.mask       <= `SMCI_MASK_RESET;
            st_q.pending    <= 6'h00;
            st_q.code       <= `SMCI_SRC_NONE;
            st_q.irq_n      <= 1'b1;
            st_q.state      <= SMCI_IRQ_IDLE;
            st_q.gap_cnt    <= 16'h0000;
        end else begin
            st_q <= st_d;
        end
    end

    // timeouts and the mode jump both follow the registered off flag
    assign read_data_o                 = st_q.rdata;
    assign watchdog_disabled_flag_o    = st_q.wd_off;
    assign suppress_timeouts_o         = st_q.wd_off;
    assign skip_to_normal_o            = st_q.wd_off;
    assign watchdog_window_open_flag_o = st_q.win_open;
    assign wake_input_divider_select_o = st_q.divider;
    assign analog_source_select_o      = st_q.source_sel;
    assign analog_buffer_enable_o      = st_q.buf_en;
    assign cyclic_period_times_eight_o = st_q.times8;
    assign interrupt_group_mask_o      = st_q.mask;
    assign irq_source_code_bits_o      = st_q.code;
    assign irq_n_o                     = st_q.irq_n;

endmodule

// ### test/smci_assertions.sv
// Purpose: port assertions for the mux, config and interrupt registers
// Assumes: one clock, synchronous active-low reset
// Notes:   gap check sized for the short simulation gap
`timescale 1ns/1ps
module smci_assertions
    import smci_pkg::*;
(
    // clock and reset
    input wire logic         clock_i,
    input wire logic         reset_n_i,
    // causes, mode and status
    input wire logic         power_on_i,
    input wire logic         reset_mode_i,
    input wire logic         ext_reset_i,
    input wire logic         low_power_mode_i,
    input wire logic         watchdog_config_pin_i,
    input wire logic         window_open_i,
    input wire smci_access_t access_i,
    input wire smci_events_t events_i,
    // outputs watched
    input wire logic   [3:0] read_data_o,
    input wire logic         watchdog_disabled_flag_o,
    input wire logic         watchdog_window_open_flag_o,
    input wire logic         suppress_timeouts_o,
    input wire logic         skip_to_normal_o,
    input wire logic         wake_input_divider_select_o,
    input wire logic   [2:0] analog_source_select_o,
    input wire logic         analog_buffer_enable_o,
    input wire logic         cyclic_period_times_eight_o,
    input wire logic   [3:0] interrupt_group_mask_o,
    input wire logic   [3:0] irq_source_code_bits_o,
    input wire logic         irq_n_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);
    // a reset cause on the same edge would win over the mux select; only power-on also wins over the config write
    logic wr_ok;
    assign wr_ok = access_i.wr & ~power_on_i & ~reset_mode_i & ~ext_reset_i;
    AST_WATCHDOG_DISABLED_FLAG_FLAG: assert property ($past(reset_n_i) |->
        watchdog_disabled_flag_o == !$past(watchdog_config_pin_i))
        else $error("watchdog off flag wrong");
    AST_WATCHDOG_DISABLED_FLAG_USE: assert property (suppress_timeouts_o ==
        watchdog_disabled_flag_o && skip_to_normal_o == suppress_timeouts_o)
        else $error("watchdog off effects wrong");
    AST_WINDOW_FLAG: assert property ($past(reset_n_i) |->
        watchdog_window_open_flag_o == $past(window_open_i))
        else $error("window flag wrong");
    AST_MUX_WRITE: assert property (wr_ok && access_i.addr == 4'hC |=>
        {wake_input_divider_select_o, analog_source_select_o}
        == $past(access_i.data)) else $error("mux write lost");
    AST_BUFFER_OFF: assert property ($past(reset_n_i) &&
        ($past(low_power_mode_i) || (analog_source_select_o == 3'h0 &&
        $past(analog_source_select_o) == 3'h0)) |-> !analog_buffer_enable_o)
        else $error("buffer on while off");
    AST_CFG_WRITE: assert property (wr_ok && access_i.addr == 4'hD |=>
        cyclic_period_times_eight_o == $past(access_i.data[2]))
        else $error("multiplier write lost");
    AST_MASK_WRITE: assert property (access_i.wr && !power_on_i &&
        access_i.addr == 4'hE |=> interrupt_group_mask_o ==
        $past(access_i.data)) else $error("mask write lost");
    AST_MASK_RETURN: assert property (access_i.wr && access_i.addr == 4'hE
        && events_i == '0 |=> read_data_o == $past(irq_source_code_bits_o))
        else $error("mask write answer wrong");
    AST_ACK_RELEASE: assert property (access_i.rd && access_i.addr == 4'hF
        && events_i == '0 |=> irq_n_o &&
        read_data_o == $past(irq_source_code_bits_o))
        else $error("source read answer wrong");
    AST_IRQ_CODE: assert property (!irq_n_o |->
        irq_source_code_bits_o inside {[4'h1:4'h6]})
        else $error("irq low without valid code");
    AST_GAP_HIGH: assert property ($rose(irq_n_o) &&
        irq_source_code_bits_o != 4'h0 |-> irq_n_o[*4])
        else $error("irq gap too short");
    AST_POWER_ON: assert property (power_on_i |=> interrupt_group_mask_o
        == 4'hF && wake_input_divider_select_o && !cyclic_period_times_eight_o
        && analog_source_select_o == 3'h0) else $error("power-on values");
    AST_RESET_MODE: assert property (reset_mode_i || ext_reset_i |=>
        analog_source_select_o == 3'h0) else $error("select not cleared");
    COV_ACK: cover property (access_i.rd && irq_source_code_bits_o != 4'h0);
    COV_GAP: cover property ($rose(irq_n_o) ##5 !irq_n_o);
    COV_BUF: cover property (analog_buffer_enable_o);
endmodule

bind smci_regs smci_assertions smci_assertions_i (.*);

// ### test/smci_host.sv
// Purpose: host model issuing register accesses to the block
// Assumes: tasks are entered just after a rising edge
// Notes:   one access per two cycles, strobe held one cycle
`timescale 1ns/1ps
module smci_host
    import smci_pkg::*;
(
    // clock
    input  wire logic   clock_i,
    // watchdog status seen by the host
    input  wire logic   window_flag_i,
    input  wire logic   resistor_missing_i,
    // register access
    output smci_access_t access_o,
    output logic        window_usable_o
);
    // the window flag means nothing without the resistor
    assign window_usable_o = window_flag_i & ~resistor_missing_i;
    initial access_o = '0;
    task automatic xfer(input logic w, input logic [3:0] a,
                        input logic [3:0] d);
        access_o <= '{wr: w, rd: !w, addr: a, data: d};
        @(posedge clock_i);
        access_o <= '0;
        @(posedge clock_i);
    endtask
endmodule

// ### test/smci_regs_tb.sv
// Purpose: self-checking bench for the mux, config and interrupt registers
// Assumes: host model drives accesses two cycles apart
// Notes:   short gap parameter keeps the run brief
`timescale 1ns/1ps
module smci_regs_tb
    import smci_pkg::*;
;
    localparam int GAP = 5;
    logic         clock_i = 1'b0;
    logic         reset_n_i = 1'b0;
    logic         power_on_i = 1'b0;
    logic         reset_mode_i = 1'b0;
    logic         ext_reset_i = 1'b0;
    logic         low_power_mode_i = 1'b0;
    logic         watchdog_config_pin_i = 1'b1;
    logic         window_open_i = 1'b0;
    smci_access_t access_i;
    smci_events_t events_i = '0;
    logic   [3:0] read_data_o, interrupt_group_mask_o;
    logic   [3:0] irq_source_code_bits_o, d, exp_q[$];
    logic   [2:0] analog_source_select_o;
    logic         watchdog_disabled_flag_o, watchdog_window_open_flag_o;
    logic         suppress_timeouts_o, skip_to_normal_o, irq_n_o;
    logic         wake_input_divider_select_o, analog_buffer_enable_o;
    logic         cyclic_period_times_eight_o;
    logic         pend = 1'b0;
    int           fails = 0;
    int           n_compared = 0;
    int           seed = 85;
    // code for each event bit, lowest bit first
    logic   [3:0] code_of [11] = '{4'h6, 4'h5, 4'h5, 4'h5, 4'h4, 4'h4,
                                   4'h4, 4'h4, 4'h3, 4'h2, 4'h1};
    int           prio_ev [6] = '{0, 5, 9, 10, 8, 1};
    smci_regs #(.GAP_CYCLES(GAP)) smci_regs_i (.*);
    smci_host smci_host_i (
        .clock_i            (clock_i),
        .window_flag_i      (watchdog_window_open_flag_o),
        .resistor_missing_i (1'b0),
        .access_o           (access_i),
        .window_usable_o    ()
    );
    always #25 clock_i = ~clock_i;
    task automatic report_and_stop;
        $display("compared %0d, failed %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [3:0] got, input logic [3:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    // the frame answer stands for one cycle after the taking edge
    always @(posedge clock_i) begin
        if (pend) chk(read_data_o, exp_q.pop_front());
        pend <= access_i.rd | (access_i.wr & (access_i.addr == 4'hE));
    end
    task automatic rd_src(input logic [3:0] e);
        exp_q.push_back(e);
        smci_host_i.xfer(1'b0, 4'hF, 4'h0);
    endtask
    task automatic wmask(input logic [3:0] m, input logic [3:0] e);
        exp_q.push_back(e);
        smci_host_i.xfer(1'b1, 4'hE, m);
    endtask
    task automatic ev(input int i);
        events_i <= smci_events_t'(11'h1 << i);
        @(posedge clock_i);
        events_i <= '0;
        repeat (3) @(posedge clock_i);
    endtask
    task automatic wait_low;
        int n;
        n = 0;
        while (irq_n_o !== 1'b0 && n < 40) begin
            @(posedge clock_i);
            n++;
        end
        if (n >= 40) begin
            fails++;
            report_and_stop();
        end
        chk({3'h0, n >= GAP - 2}, 4'h1);
    endtask
    initial begin
        repeat (10) @(posedge clock_i);
        reset_n_i <= 1'b1;
        @(posedge clock_i);
        @(posedge clock_i);
        chk(interrupt_group_mask_o, 4'hF);
        chk({wake_input_divider_select_o, analog_source_select_o}, 4'h8);
        chk(irq_source_code_bits_o, 4'h0);
        for (int k = 0; k < 12; k++) begin
            d = 4'($random(seed));
            low_power_mode_i <= d[0] ^ d[3];
            smci_host_i.xfer(1'b1, 4'hC, d);
            smci_host_i.xfer(1'b1, 4'hD, d);
            watchdog_config_pin_i <= d[1];
            window_open_i <= d[2];
            repeat (2) @(posedge clock_i);
            chk({wake_input_divider_select_o, analog_source_select_o}, d);
            chk({3'h0, cyclic_period_times_eight_o}, {3'h0, d[2]});
            chk({3'h0, analog_buffer_enable_o}, {3'h0,
                (d[2:0] != 3'h0) & ~low_power_mode_i});
            chk({2'h0, watchdog_disabled_flag_o, watchdog_window_open_flag_o},
                {2'h0, ~d[1], d[2]});
        end
        for (int k = 0; k < 3; k++) begin
            smci_host_i.xfer(1'b1, 4'hC, 4'h3);
            smci_host_i.xfer(1'b1, 4'hD, 4'h4);
            wmask(4'h0, 4'h0);
            {power_on_i, ext_reset_i, reset_mode_i} <= 3'(1 << k);
            @(posedge clock_i);
            {power_on_i, ext_reset_i, reset_mode_i} <= 3'h0;
            repeat (2) @(posedge clock_i);
            chk({wake_input_divider_select_o, analog_source_select_o},
                (k == 2) ? 4'h8 : 4'h0);
            chk(interrupt_group_mask_o, (k == 2) ? 4'hF : 4'h0);
        end
        for (int i = 0; i < 11; i++) begin
            ev(i);
            chk({3'h0, irq_n_o}, 4'h0);
            rd_src(code_of[i]);
            chk({irq_n_o, 3'h0}, 4'h8);
            chk(irq_source_code_bits_o, 4'h0);
            repeat (8) @(posedge clock_i);
        end
        wmask(4'h0, 4'h0);
        foreach (prio_ev[j]) if (j != 0 && j != 3) ev(prio_ev[j]);
        ev(6);
        chk({3'h0, irq_n_o}, 4'h1);
        chk(irq_source_code_bits_o, 4'h0);
        ev(3);
        wmask(4'hF, 4'h5);
        rd_src(4'h5);
        repeat (8) @(posedge clock_i);
        foreach (prio_ev[j]) ev(prio_ev[j]);
        for (int c = 1; c <= 6; c++) begin
            rd_src(4'(c));
            if (c < 6) wait_low();
        end
        chk({irq_n_o, irq_source_code_bits_o[2:0]}, 4'h8);
        report_and_stop();
    end
endmodule
